// file: logic/sample_buffer_defs.vh
// Register map, field positions and reset values of the sample buffer.
// Assumes byte-wide register access by a host-side serial front end.
`ifndef SAMPLE_BUFFER_DEFS_VH
`define SAMPLE_BUFFER_DEFS_VH
`define ADDR_WATERMARK 8'h13
`define ADDR_CONTROL 8'h14
`define ADDR_COUNT_LOW 8'h15
`define ADDR_STATUS 8'h16
`define ADDR_DATA_OUT 8'h17
`define WATERMARK_RESET 8'h00
`define CONTROL_RESET 8'h00
`define CTRL_READOUT_BIT 7
`define CTRL_DEPTH_HI 3
`define CTRL_DEPTH_LO 2
`define CTRL_MODE_HI 1
`define CTRL_MODE_LO 0
`define STAT_FULL_BIT 7
`define STAT_WTM_BIT 6
`define STAT_OVR_BIT 5
`define STAT_NEMPTY_BIT 4
`define MODE_BYPASS 2'h0
`define MODE_FILL_ONCE 2'h1
`define MODE_STREAM 2'h2
`define MODE_STREAM_HOLD 2'h3
`endif

// file: logic/skid_buffer.v
// Two-entry valid/ready buffer in front of the sample store.
// Assumes source and sink on the same clock.
`timescale 1ns/1ps
module skid_buffer #(
  parameter WIDTH = 8
) (
  input wire mclk,
  input wire sys_rst,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] slot_q [0:1];
  reg rd_q;
  reg wr_q;
  reg [1:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = slot_q[rd_q];
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      cnt_q <= 2'h0;
      slot_q[0] <= {WIDTH{1'b0}};
      slot_q[1] <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        slot_q[wr_q] <= in_data;
        wr_q <= ~wr_q;
      end
      if (pop)
        rd_q <= ~rd_q;
      if (push && !pop)
        cnt_q <= cnt_q + 2'h1;
      else if (pop && !push)
        cnt_q <= cnt_q - 2'h1;
    end
  end
endmodule // skid_buffer

// file: logic/sample_buffer_control.v
// Sample buffer with its control, status and readout registers.
// Assumes a host front end giving byte-wide reads and writes on mclk.
// Functional notes
// - Watermark flag when samples reach threshold
// - Buffer-read command sets readout mode bit
// - No sample writes while readout mode set
// - Mode field picks bypass/fill/stream/hold
// - Hold mode: event empties buffer, resets pointers
// - Status bit 7 shows buffer full
// - Overflow flag on write into full buffer, except in stream mode
// - Host reads bytes from output register
`timescale 1ns/1ps
`include "sample_buffer_defs.vh"
module sample_buffer_control #(
  parameter SAMPLE_BYTES = 6,
  parameter MAX_SAMPLES = 128,
  parameter ADDR_W = 10
) (
  input wire mclk,
  input wire sys_rst,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  input wire readout_cmd,
  input wire motion_event,
  input wire byte_valid,
  output wire byte_ready,
  input wire [7:0] byte_data,
  input wire sample_last
);
  localparam DEPTH = MAX_SAMPLES * SAMPLE_BYTES;
  reg [7:0] mem [0:DEPTH-1];
  reg [7:0] watermark_level_q;
  reg readout_q;
  reg [1:0] depth_q;
  reg [1:0] mode_q;
  reg overrun_flag_q;
  reg [ADDR_W-1:0] wptr_q;
  reg [ADDR_W-1:0] rptr_q;
  reg [ADDR_W:0] bytes_q;
  reg [7:0] samples_q;
  reg [7:0] data_out_q;
  reg dropping_q;
  wire sk_valid;
  wire sk_ready;
  wire [7:0] sk_data;
  wire sk_last;
  skid_buffer #(.WIDTH(9)) u_skid (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .in_valid(byte_valid),
    .in_ready(byte_ready),
    .in_data({sample_last, byte_data}),
    .out_valid(sk_valid),
    .out_ready(sk_ready),
    .out_data({sk_last, sk_data})
  );
  // Capacity in samples and bytes from the depth code
  wire [7:0] cap_samples = 8'h10 << depth_q;
  wire [31:0] cap_bytes_wide = cap_samples * SAMPLE_BYTES;
  wire [ADDR_W:0] cap_bytes = cap_bytes_wide[ADDR_W:0];
  wire [ADDR_W-1:0] cap_top = cap_bytes[ADDR_W-1:0];
  wire [ADDR_W-1:0] cap_last = cap_top - 1'b1;
  // Sample length cut to counter widths from the 32-bit parameter
  wire [31:0] sample_len_wide = SAMPLE_BYTES;
  wire [ADDR_W:0] sample_len = sample_len_wide[ADDR_W:0];
  wire [ADDR_W-1:0] ptr_step = sample_len[ADDR_W-1:0];
  wire [7:0] phase_last = sample_len_wide[7:0] - 8'h01;
  // Byte position of the read pointer inside its sample
  reg [7:0] rd_phase_q;
  // Full compares whole samples, so a partial sample never reads as full
  wire full = (samples_q == cap_samples) && (mode_q != `MODE_BYPASS);
  wire not_empty = (bytes_q != {(ADDR_W+1){1'b0}});
  // A zero threshold keeps the watermark flag quiet
  wire wtm_hit = (watermark_level_q != 8'h00) &&
    (samples_q >= watermark_level_q);
  wire host_rd_data = reg_rd && (reg_addr == `ADDR_DATA_OUT) && readout_q;
  wire status_rd = reg_rd && (reg_addr == `ADDR_STATUS);
  // Pops of an empty store are ignored
  wire pop = host_rd_data && not_empty;
  wire flush = (mode_q == `MODE_STREAM_HOLD) && motion_event;
  // Bypass holds the store empty every cycle, like a flush that never ends
  wire clear_all = flush || (mode_q == `MODE_BYPASS);
  // Stream drops whole oldest sample; keep consumer busy while dropping
  wire stream_evict = (mode_q == `MODE_STREAM) && full;
  // Upstream stalls during readout, so no word is lost
  assign sk_ready = !readout_q && !flush;
  wire take = sk_valid && sk_ready;
  // Mode 11 stores like fill-once until an event empties the store
  wire store_ok = (mode_q != `MODE_BYPASS) &&
    (!full || stream_evict || dropping_q);
  wire push = take && store_ok && !dropping_q;
  wire evict = take && stream_evict && !dropping_q && sk_last;
  // Overflow counts a whole dropped sample, flagged on its last byte
  wire overrun_set = take && sk_last && full && !stream_evict;
  wire drop_byte = take && !push && !stream_evict;
  // Readout stalls input, so a pop never meets a push
  wire [ADDR_W:0] bytes_d = bytes_q + {{ADDR_W{1'b0}}, push} -
    {{ADDR_W{1'b0}}, pop};
  // While a stream sample lands on a full store, the count runs past the
  // capacity for up to one sample and falls back on its last byte
  wire [ADDR_W:0] bytes_next = evict ? bytes_d - sample_len : bytes_d;
  // Pointers wrap at the selected capacity, not at the array size
  wire [ADDR_W-1:0] wptr_inc = (wptr_q == cap_last) ?
    {ADDR_W{1'b0}} : wptr_q + 1'b1;
  wire [ADDR_W-1:0] rptr_inc = (rptr_q == cap_last) ?
    {ADDR_W{1'b0}} : rptr_q + 1'b1;
  // Eviction moves the read pointer past one whole sample
  wire [ADDR_W-1:0] rptr_skip = (rptr_q >= cap_top - ptr_step) ?
    rptr_q + ptr_step - cap_top : rptr_q + ptr_step;
  // Evicting and storing one sample leaves the sample count unchanged
  wire sample_in = push && sk_last && !evict && !full;
  // A sample leaves the count when its last byte is popped
  wire sample_out = pop && (rd_phase_q == phase_last) &&
    (samples_q != 8'h00);
  wire [7:0] rd_phase_inc = (rd_phase_q == phase_last) ?
    8'h00 : rd_phase_q + 8'h01;
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      watermark_level_q <= `WATERMARK_RESET;
      readout_q <= 1'b0;
      depth_q <= 2'h0;
      mode_q <= 2'h0;
    end else begin
      if (reg_wr && reg_addr == `ADDR_WATERMARK)
        watermark_level_q <= reg_wdata;
      if (reg_wr && reg_addr == `ADDR_CONTROL) begin
        depth_q <= reg_wdata[`CTRL_DEPTH_HI:`CTRL_DEPTH_LO];
        mode_q <= reg_wdata[`CTRL_MODE_HI:`CTRL_MODE_LO];
      end
      // Command set wins over a simultaneous host clear
      if (readout_cmd)
        readout_q <= 1'b1;
      else if (reg_wr && reg_addr == `ADDR_CONTROL)
        readout_q <= reg_wdata[`CTRL_READOUT_BIT];
    end
  end
  // Storage carries no reset; nothing is read before it is written
  always @(posedge mclk) begin
    if (push && !clear_all)
      mem[wptr_q] <= sk_data;
  end
  // Read data is registered; the host sees a popped byte one cycle later
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      data_out_q <= 8'h00;
    end else if (pop && !clear_all) begin
      data_out_q <= mem[rptr_q];
    end
  end
  // Changing the depth with data stored scrambles the order; flush first
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wptr_q <= {ADDR_W{1'b0}};
      rptr_q <= {ADDR_W{1'b0}};
    end else if (clear_all) begin
      wptr_q <= {ADDR_W{1'b0}};
      rptr_q <= {ADDR_W{1'b0}};
    end else begin
      if (push)
        wptr_q <= wptr_inc;
      // Oldest sample gives way; a pop never meets it, readout stalls input
      if (evict)
        rptr_q <= rptr_skip;
      else if (pop)
        rptr_q <= rptr_inc;
    end
  end
  // Sample count follows whole samples; the byte count follows every byte
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      bytes_q <= {(ADDR_W+1){1'b0}};
      samples_q <= 8'h00;
      rd_phase_q <= 8'h00;
    end else if (clear_all) begin
      bytes_q <= {(ADDR_W+1){1'b0}};
      samples_q <= 8'h00;
      rd_phase_q <= 8'h00;
    end else begin
      bytes_q <= bytes_next;
      if (sample_in)
        samples_q <= samples_q + 8'h01;
      else if (sample_out)
        samples_q <= samples_q - 8'h01;
      if (pop)
        rd_phase_q <= rd_phase_inc;
    end
  end
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      overrun_flag_q <= 1'b0;
      dropping_q <= 1'b0;
    end else if (clear_all) begin
      dropping_q <= 1'b0;
    end else begin
      // Overflow is sticky; a status read clears it outside bypass and flush, a new overflow wins
      if (overrun_set)
        overrun_flag_q <= 1'b1;
      else if (status_rd)
        overrun_flag_q <= 1'b0;
      // Fill-once drops the rest of a sample that met a full buffer
      if (drop_byte)
        dropping_q <= !sk_last;
    end
  end
  always @* begin
    case (reg_addr)
      `ADDR_WATERMARK: reg_rdata = watermark_level_q;
      `ADDR_CONTROL: reg_rdata = {readout_q, 3'h0, depth_q, mode_q};
      `ADDR_COUNT_LOW: reg_rdata = bytes_q[7:0];
      `ADDR_STATUS: reg_rdata = {full, wtm_hit, overrun_flag_q,
        not_empty, 4'h0};
      `ADDR_DATA_OUT: reg_rdata = data_out_q;
      default: reg_rdata = 8'h00;
    endcase
  end
endmodule // sample_buffer_control

// file: testbench/sample_buffer_checker.sv
// Checker on the sample buffer ports.
// Assumes a bind onto the design top.
`timescale 1ns/1ps
module sample_buffer_checker (
  input wire mclk,
  input wire sys_rst,
  input wire reg_rd,
  input wire reg_wr,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire readout_cmd
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  property p_cmd;
    readout_cmd ##1 reg_addr == 8'h14 |-> reg_rdata[7]; endproperty
  a_cmd: assert property (p_cmd) else $error("cmd");
  property p_wtm;
    reg_wr && reg_addr == 8'h13 ##1 reg_addr == 8'h13
      |-> reg_rdata == $past(reg_wdata); endproperty
  a_wtm: assert property (p_wtm) else $error("wtm");
  property p_ctl;
    reg_wr && reg_addr == 8'h14 ##1 reg_addr == 8'h14
      |-> reg_rdata[3:0] == $past(reg_wdata[3:0]); endproperty
  a_ctl: assert property (p_ctl) else $error("ctl");
  property p_rsv; reg_addr == 8'h14 |-> reg_rdata[6:4] == 3'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("rsv");
  property p_srsv; reg_addr == 8'h16 |-> reg_rdata[3:2] == 2'h0;
  endproperty
  a_srsv: assert property (p_srsv) else $error("srsv");
  property p_full; reg_addr == 8'h16 && reg_rdata[7] |-> reg_rdata[4];
  endproperty
  a_full: assert property (p_full) else $error("full");
  property p_unmap;
    reg_addr < 8'h13 || reg_addr > 8'h17 |-> reg_rdata == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmap");
  property p_hold;
    reg_addr == 8'h17 && !reg_rd ##1 reg_addr == 8'h17
      |-> $stable(reg_rdata); endproperty
  a_hold: assert property (p_hold) else $error("hold");
  cover property (reg_addr == 8'h16 && reg_rdata[7]);
  cover property (reg_rd && reg_addr == 8'h17);
  cover property (readout_cmd);
endmodule // sample_buffer_checker

// file: testbench/sensor_byte_source.sv
// Sensor-side byte source for the sample stream.
// Assumes the bench raises budget to ask for bytes.
`timescale 1ns/1ps
module sensor_byte_source (
  input wire mclk,
  input wire sys_rst,
  input wire [15:0] budget,
  input wire byte_ready,
  output reg byte_valid,
  output reg [7:0] byte_data,
  output wire sample_last,
  output reg [15:0] sent
);
  assign sample_last = sent % 16'd6 == 16'd5;
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      byte_valid <= 1'b0;
      sent <= 16'h0;
      byte_data <= 8'h00;
    end else if (!byte_valid || byte_ready) begin
      sent <= sent + byte_valid;
      byte_valid <= sent + byte_valid < budget;
      // Idle line toggles so a stale byte never looks valid
      byte_data <= sent + byte_valid < budget ?
        (sent[7:0] + byte_valid) ^ 8'ha5 : ~byte_data;
    end
  end
endmodule // sensor_byte_source

// file: testbench/test_sample_buffer_control.sv
// Self-checking bench for the sample buffer control block.
// Assumes the byte source and checker are compiled first.
`timescale 1ns/1ps
module test_sample_buffer_control;
  reg mclk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  reg readout_cmd = 1'b0, motion_event = 1'b0;
  reg [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, v, wtm;
  reg [15:0] budget = 16'h0;
  wire [7:0] reg_rdata, byte_data;
  wire [15:0] sent;
  wire byte_valid, byte_ready, sample_last;
  integer mismatches = 0, samples_checked = 0, k, i;
  always #4 mclk = ~mclk;
  sample_buffer_control dut (.mclk(mclk), .sys_rst(sys_rst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .readout_cmd(readout_cmd), .motion_event(motion_event),
    .byte_valid(byte_valid), .byte_ready(byte_ready),
    .byte_data(byte_data), .sample_last(sample_last));
  sensor_byte_source src (.mclk(mclk), .sys_rst(sys_rst), .budget(budget),
    .byte_ready(byte_ready), .byte_valid(byte_valid),
    .byte_data(byte_data), .sample_last(sample_last), .sent(sent));
  task chk(input string n, input [7:0] s, input [7:0] e);
    begin
      samples_checked = samples_checked + 1;
      if (s !== e) begin
        mismatches = mismatches + 1;
        $display("unexpected %0s exp %h seen %h", n, e, s);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input p);
    begin
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= p;
      @(negedge mclk);
      v = reg_rdata;
      @(posedge mclk);
      reg_rd <= 1'b0;
    end
  endtask
  task st(input [7:0] c, input [7:0] s);
    begin
      rd(8'h15, 1'b0);
      chk("count", v, c);
      rd(8'h16, 1'b0);
      chk("status", v, s);
    end
  endtask
  task feed(input [15:0] n);
    begin
      @(posedge mclk);
      budget <= budget + n;
      repeat (2) @(posedge mclk);
      for (k = 0; k < 500 && sent != budget; k = k + 1)
        @(posedge mclk);
      repeat (4) @(posedge mclk);
    end
  endtask
  function [7:0] exp_byte(input integer n);
    exp_byte = n[7:0] ^ 8'ha5;
  endfunction
  task readout_pulse;
    begin
      @(posedge mclk);
      reg_addr <= 8'h14;
      readout_cmd <= 1'b1;
      @(posedge mclk);
      readout_cmd <= 1'b0;
      @(negedge mclk);
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial begin
    #200000;
    mismatches = mismatches + 1;
    give_verdict;
  end
  initial begin
    void'($urandom(32'he4b7e472));
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(8'h14, 1'b0);
    chk("control", v, 8'h00);
    st(8'h00, 8'h00);
    rd(8'h20, 1'b0);
    chk("unmapped", v, 8'h00);
    wtm = 8'h01 + $urandom % 14;
    wr(8'h13, wtm);
    wr(8'h14, 8'h01);
    feed(wtm * 6 - 6);
    st((wtm - 1) * 6, wtm > 1 ? 8'h10 : 8'h00);
    feed(6);
    st(wtm * 6, 8'h50);
    feed(102 - wtm * 6);
    st(8'h60, 8'hf0);
    readout_pulse;
    chk("readout", reg_rdata, 8'h81);
    for (i = 0; i < 7; i = i + 1) begin
      rd(8'h17, 1'b1);
      if (i > 0) chk("data", v, exp_byte(i - 1));
    end
    rd(8'h16, 1'b1);
    chk("status", v, 8'h70);
    st(8'h59, 8'h50);
    feed(12);
    st(8'h59, 8'h50);
    wr(8'h14, 8'h0a);
    feed(0);
    st(8'h65, 8'h50);
    wr(8'h14, 8'h0b);
    @(posedge mclk);
    motion_event <= 1'b1;
    @(posedge mclk);
    motion_event <= 1'b0;
    st(8'h00, 8'h00);
    wr(8'h14, 8'h00);
    feed(12);
    st(8'h00, 8'h00);
    wr(8'h14, 8'h02);
    feed(102);
    st(8'h60, 8'hd0);
    readout_pulse;
    chk("readout", reg_rdata, 8'h82);
    rd(8'h17, 1'b1);
    rd(8'h17, 1'b1);
    chk("stream", v, exp_byte(132));
    give_verdict;
  end
endmodule // test_sample_buffer_control
bind sample_buffer_control sample_buffer_checker chk_i (.mclk(mclk),
  .sys_rst(sys_rst), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .readout_cmd(readout_cmd));
